// ==== pkg/eiu_cfg.svh ====
`ifndef EIU_CFG_SVH
`define EIU_CFG_SVH
`define EIU_RESET_VECTOR     32'h0000_0000
`define EIU_OFS_FETCH_FAULT  12'h010
`define EIU_OFS_MIS_BRANCH   12'h020
`define EIU_OFS_RESERVED_OP  12'h030
`define EIU_OFS_PRIVILEGE    12'h040
`define EIU_OFS_MIS_DATA     12'h050
`define EIU_OFS_DATA_FAULT   12'h060
`define EIU_OFS_BREAKPOINT   12'h080
`define EIU_OFS_REINIT       12'h000
`define EIU_OFS_IRQ_BASE     12'h200
`define EIU_OFS_STEP         12'h010
`define EIU_LEVEL_MAX        4'hf
`define EIU_TRAP_PRIV_LIMIT  8'h40
`define EIU_IRQ_USER_TIMER_TWO    11
`define EIU_IRQ_EXT_PIN      9
`define EIU_IRQ_SERIAL       7
`define EIU_IRQ_PARALLEL     5
`define EIU_IRQ_TIMER_ONE    3
`endif

// ==== pkg/eiu_pkg.sv ====
package eiu_pkg;
    typedef enum logic [4:0] {
        EIU_SRC_NONE,
        EIU_SRC_REINIT,
        EIU_SRC_FETCH,
        EIU_SRC_MIS_BRANCH,
        EIU_SRC_RESERVED_OP,
        EIU_SRC_PRIVILEGE,
        EIU_SRC_BREAKPOINT,
        EIU_SRC_TRAP,
        EIU_SRC_MIS_DATA,
        EIU_SRC_DATA_FAULT,
        EIU_SRC_IRQ
    } eiu_src_t;
    typedef enum logic [1:0] {
        EIU_RUN,
        EIU_RETURN
    } eiu_state_t;
endpackage

// ==== rtl/eiu_exception_unit.sv ====
`timescale 1ns/1ps
`include "eiu_cfg.svh"

module eiu_exception_unit (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        INSTR_VALID,
    input  wire logic [31:0] EXEC_ADDR,
    input  wire logic        NULLIFY,
    input  wire logic        USER_MODE,
    input  wire logic        FETCH_FAULT,
    input  wire logic        BRANCH_TARGET_VALID,
    input  wire logic [31:0] BRANCH_TARGET,
    input  wire logic        RESERVED_OP,
    input  wire logic        PRIV_REG_WRITE,
    input  wire logic        TRAP_VALID,
    input  wire logic [7:0]  TRAP_VECTOR,
    input  wire logic        SW_BREAKPOINT_EMU,
    input  wire logic        DATA_ACCESS_VALID,
    input  wire logic [31:0] DATA_ADDR,
    input  wire logic        DATA_ADDR_UNDEFINED,
    input  wire logic        REINIT_REQ,
    input  wire logic        USER_TIMER_TWO_IRQ,
    input  wire logic        EXT_PIN_IRQ,
    input  wire logic        SERIAL_IRQ,
    input  wire logic        PARALLEL_IRQ,
    input  wire logic        TIMER_ONE_IRQ,
    input  wire logic        RETURN_REQ,
    input  wire logic [31:0] VECTOR_BASE,
    input  wire logic [31:0] BREAKPOINT_ADDRESS_REG,
    input  wire logic        BREAKPOINT_ENABLE_BIT,
    input  wire logic        EXCEPTION_ENABLE_SET,
    input  wire logic        LEVEL_WRITE,
    input  wire logic [3:0]  LEVEL_WRITE_DATA,
    output logic             EXCEPTION_ENABLE_BIT,
    output logic [3:0]       PROCESSOR_LEVEL,
    output logic [3:0]       SAVED_LEVEL,
    output logic             SAVED_ENABLE,
    output logic             SAVED_NULLIFY_FLAG,
    output logic             TAKE,
    output logic [31:0]      TARGET_ADDR,
    output logic [31:0]      SAVED_ADDR,
    output logic             RESUME_NEXT,
    output logic             SKIP_RETURN_INSTR,
    output logic             RETURN_DONE,
    output logic             KILL_INSTR,
    output logic             MIS_DATA_PENDING,
    output logic             DATA_FAULT_PENDING
);
    import eiu_pkg::*;

    function automatic logic [31:0] vec_addr(input logic [31:0] base, input logic [11:0] ofs);
        vec_addr = base | {20'h00000, ofs};
    endfunction

    logic [15:1] irq_lines;
    logic [3:0]  irq_num;
    logic        irq_ok;
    eiu_src_t    next_src;
    logic [11:0] next_ofs;
    logic        bp_hit;
    logic        sync_ok;
    logic        reinit_q;
    logic        reinit_pend;

    always_comb
    begin
        irq_lines                        = '0;
        irq_lines[`EIU_IRQ_USER_TIMER_TWO]   = USER_TIMER_TWO_IRQ;
        irq_lines[`EIU_IRQ_EXT_PIN]     = EXT_PIN_IRQ;
        irq_lines[`EIU_IRQ_SERIAL]      = SERIAL_IRQ;
        irq_lines[`EIU_IRQ_PARALLEL]    = PARALLEL_IRQ;
        irq_lines[`EIU_IRQ_TIMER_ONE]   = TIMER_ONE_IRQ;
    end

    // Highest line wins; acceptance needs the line above the current level.
    always_comb
    begin
        irq_num = 4'h0;
        for (int n = 1; n <= 15; n++)
        begin
            if (irq_lines[n])
            begin
                irq_num = 4'(n);
            end
        end
        irq_ok = (irq_num != 4'h0) && EXCEPTION_ENABLE_BIT
                 && (PROCESSOR_LEVEL < irq_num);
    end

    assign bp_hit  = INSTR_VALID && (EXEC_ADDR == BREAKPOINT_ADDRESS_REG)
                     && BREAKPOINT_ENABLE_BIT && EXCEPTION_ENABLE_BIT;
    assign sync_ok = INSTR_VALID && !NULLIFY;

    always_comb
    begin
        next_src = EIU_SRC_NONE;
        next_ofs = 12'h000;
        // Fixed priority chain; lower entries only win when nothing above fires.
        if (reinit_pend)
        begin
            next_src = EIU_SRC_REINIT;
            next_ofs = `EIU_OFS_REINIT;
        end
        else if (sync_ok && FETCH_FAULT)
        begin
            next_src = EIU_SRC_FETCH;
            next_ofs = `EIU_OFS_FETCH_FAULT;
        end
        else if (sync_ok && BRANCH_TARGET_VALID && (BRANCH_TARGET[1:0] != 2'b00))
        begin
            next_src = EIU_SRC_MIS_BRANCH;
            next_ofs = `EIU_OFS_MIS_BRANCH;
        end
        else if (sync_ok && RESERVED_OP)
        begin
            next_src = EIU_SRC_RESERVED_OP;
            next_ofs = `EIU_OFS_RESERVED_OP;
        end
        else if (sync_ok && USER_MODE && (PRIV_REG_WRITE
                 || (TRAP_VALID && TRAP_VECTOR <= `EIU_TRAP_PRIV_LIMIT)))
        begin
            next_src = EIU_SRC_PRIVILEGE;
            next_ofs = `EIU_OFS_PRIVILEGE;
        end
        else if (bp_hit)
        begin
            next_src = EIU_SRC_BREAKPOINT;
            next_ofs = `EIU_OFS_BREAKPOINT;
        end
        else if (sync_ok && TRAP_VALID)
        begin
            next_src = EIU_SRC_TRAP;
            next_ofs = {TRAP_VECTOR, 4'h0};
        end
        else if (MIS_DATA_PENDING && EXCEPTION_ENABLE_BIT)
        begin
            next_src = EIU_SRC_MIS_DATA;
            next_ofs = `EIU_OFS_MIS_DATA;
        end
        else if (DATA_FAULT_PENDING && EXCEPTION_ENABLE_BIT)
        begin
            next_src = EIU_SRC_DATA_FAULT;
            next_ofs = `EIU_OFS_DATA_FAULT;
        end
        else if (irq_ok)
        begin
            next_src = EIU_SRC_IRQ;
            next_ofs = `EIU_OFS_IRQ_BASE + {4'h0, irq_num, 4'h0};
        end
    end

    // Re-initialise request is edge sensed and held until taken.
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            reinit_q    <= 1'b0;
            reinit_pend <= 1'b0;
        end
        else
        begin
            reinit_q    <= REINIT_REQ;
            reinit_pend <= (REINIT_REQ && !reinit_q)
                           || (reinit_pend && next_src != EIU_SRC_REINIT);
        end
    end

    // Data exceptions are sampled every cycle and latched until accepted; a new event beats the clear.
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            MIS_DATA_PENDING   <= 1'b0;
            DATA_FAULT_PENDING <= 1'b0;
        end
        else
        begin
            MIS_DATA_PENDING   <= (DATA_ACCESS_VALID && DATA_ADDR[1:0] != 2'b00)
                                  || (MIS_DATA_PENDING && next_src != EIU_SRC_MIS_DATA);
            DATA_FAULT_PENDING <= (DATA_ACCESS_VALID && DATA_ADDR_UNDEFINED)
                                  || (DATA_FAULT_PENDING && next_src != EIU_SRC_DATA_FAULT);
        end
    end

    // Status register: level, enable; saved copy taken from the pre-entry values.
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            PROCESSOR_LEVEL      <= `EIU_LEVEL_MAX;
            EXCEPTION_ENABLE_BIT <= 1'b0;
            SAVED_LEVEL          <= `EIU_LEVEL_MAX;
            SAVED_ENABLE         <= 1'b0;
            SAVED_NULLIFY_FLAG   <= 1'b0;
        end
        else if (next_src != EIU_SRC_NONE)
        begin
            SAVED_LEVEL          <= PROCESSOR_LEVEL;
            SAVED_ENABLE         <= EXCEPTION_ENABLE_BIT;
            SAVED_NULLIFY_FLAG   <= NULLIFY;
            EXCEPTION_ENABLE_BIT <= 1'b0;
            PROCESSOR_LEVEL      <= (next_src == EIU_SRC_IRQ) ? irq_num
                                    : `EIU_LEVEL_MAX;
        end
        else if (RETURN_REQ)
        begin
            // An entry presented with the return wins; this restore is then skipped and RETURN_DONE stays low.
            PROCESSOR_LEVEL      <= SAVED_LEVEL;
            EXCEPTION_ENABLE_BIT <= SAVED_ENABLE;
        end
        else
        begin
            // Software lowers the level to open the interrupt window; an entry wins a clash.
            EXCEPTION_ENABLE_BIT <= EXCEPTION_ENABLE_BIT | EXCEPTION_ENABLE_SET;
            PROCESSOR_LEVEL      <= LEVEL_WRITE ? LEVEL_WRITE_DATA : PROCESSOR_LEVEL;
        end
    end

    // Dispatch outputs; synchronous requests are decided in the cycle presented, re-initialise and data requests from their pending flags.
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            TAKE        <= 1'b0;
            TARGET_ADDR <= `EIU_RESET_VECTOR;
            SAVED_ADDR  <= 32'h0000_0000;
            RESUME_NEXT <= 1'b0;
            KILL_INSTR  <= 1'b0;
        end
        else
        begin
            TAKE       <= (next_src != EIU_SRC_NONE);
            KILL_INSTR <= (next_src != EIU_SRC_NONE);
            if (next_src != EIU_SRC_NONE)
            begin
                TARGET_ADDR <= vec_addr(VECTOR_BASE, next_ofs);
                SAVED_ADDR  <= (next_src == EIU_SRC_BREAKPOINT) ? BREAKPOINT_ADDRESS_REG
                               : EXEC_ADDR;
                RESUME_NEXT <= (next_src == EIU_SRC_TRAP) && !SW_BREAKPOINT_EMU;
            end
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            RETURN_DONE       <= 1'b0;
            SKIP_RETURN_INSTR <= 1'b0;
        end
        else
        begin
            RETURN_DONE       <= RETURN_REQ && (next_src == EIU_SRC_NONE);
            SKIP_RETURN_INSTR <= RETURN_REQ && (next_src == EIU_SRC_NONE)
                                 && SAVED_NULLIFY_FLAG;
        end
    end

    property p_irq_level;
        @(posedge CLK) disable iff (SYS_RST)
        (next_src == EIU_SRC_IRQ) |=> (TAKE && PROCESSOR_LEVEL == $past(irq_num)
            && TARGET_ADDR == ($past(VECTOR_BASE) | {20'h00000, 4'h2, $past(irq_num), 4'h0}));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq level or vector wrong");

    property p_exc_level;
        @(posedge CLK) disable iff (SYS_RST)
        (next_src != EIU_SRC_NONE && next_src != EIU_SRC_IRQ) |=> PROCESSOR_LEVEL == 4'hf;
    endproperty
    a_exc_level: assert property (p_exc_level) else $error("exception level not 15");

    property p_irq_gate;
        @(posedge CLK) disable iff (SYS_RST)
        (next_src == EIU_SRC_IRQ) |-> (EXCEPTION_ENABLE_BIT && PROCESSOR_LEVEL < irq_num);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq taken while gated");

    property p_fetch;
        @(posedge CLK) disable iff (SYS_RST)
        (INSTR_VALID && !NULLIFY && FETCH_FAULT && !reinit_pend)
        |=> (TAKE && TARGET_ADDR == ($past(VECTOR_BASE) | 32'h10) && SAVED_ADDR == $past(EXEC_ADDR));
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch fault not dispatched");

    property p_nullify;
        @(posedge CLK) disable iff (SYS_RST)
        (NULLIFY) |-> !(next_src inside {EIU_SRC_FETCH, EIU_SRC_MIS_BRANCH, EIU_SRC_PRIVILEGE});
    endproperty
    a_nullify: assert property (p_nullify) else $error("nullified fault taken");

    property p_bp;
        @(posedge CLK) disable iff (SYS_RST)
        (next_src == EIU_SRC_BREAKPOINT)
        |=> (SAVED_ADDR == $past(BREAKPOINT_ADDRESS_REG) && KILL_INSTR && !RESUME_NEXT);
    endproperty
    a_bp: assert property (p_bp) else $error("breakpoint trap wrong");

    sequence s_data_pend;
        MIS_DATA_PENDING && !EXCEPTION_ENABLE_BIT;
    endsequence
    property p_data_hold;
        @(posedge CLK) disable iff (SYS_RST)
        s_data_pend |=> MIS_DATA_PENDING;
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data exception dropped");

    property p_save_status;
        @(posedge CLK) disable iff (SYS_RST)
        (next_src != EIU_SRC_NONE) |=> (SAVED_LEVEL == $past(PROCESSOR_LEVEL)
            && !EXCEPTION_ENABLE_BIT);
    endproperty
    a_save_status: assert property (p_save_status) else $error("status not saved");

    property p_return;
        @(posedge CLK) disable iff (SYS_RST)
        (RETURN_REQ && next_src == EIU_SRC_NONE)
        |=> (PROCESSOR_LEVEL == $past(SAVED_LEVEL) && RETURN_DONE
             && SKIP_RETURN_INSTR == $past(SAVED_NULLIFY_FLAG));
    endproperty
    a_return: assert property (p_return) else $error("return restore wrong");

endmodule // eiu_exception_unit

// ==== testbench/eiu_irq_sources.sv ====
`timescale 1ns/1ps
module eiu_irq_sources (
    input  wire logic       CLK,
    input  wire logic       SYS_RST,
    input  wire logic [4:0] raise,
    input  wire logic [4:0] drop,
    output logic      [4:0] lines
);
    // A peripheral keeps its request level up until it is serviced, so a refused
    // request is still present when the unit looks again.
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            lines <= 5'h00;
        else
            lines <= (lines | raise) & ~drop;
    end
endmodule // eiu_irq_sources

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import eiu_pkg::*;
    typedef struct packed {logic [31:0] tgt; logic [31:0] sav; logic chk; logic [3:0] lvl;} eiu_exp_t;
    logic        clk, rst, iv, nul, usr, ff, btv, rop, prw, tv, swb, dav, dau, rin, rq, bpe, ees;
    logic        lw;
    logic [3:0]  lwd;
    logic [31:0] ea, bt, da, vb, breakpoint_address_reg, tgt, sav;
    logic [7:0]  tvec;
    logic [4:0]  raise, drop, lines;
    logic        eeb, sen, snf, take, rnx, skp, rdn, kil, mdp, dfp;
    logic [3:0]  pl, slv;
    eiu_exp_t    exp_q[$];
    eiu_exp_t    e;
    int          err_count, total_checks;
    int          seq[7] = '{6, 0, 1, 2, 3, 4, 5};
    logic [11:0] ofs[7] = '{12'h010, 12'h020, 12'h040, 12'h040, 12'h030, 12'h450, 12'h000};

    eiu_irq_sources src (.CLK(clk), .SYS_RST(rst), .raise(raise), .drop(drop), .lines(lines));

    eiu_exception_unit dut (
        .CLK(clk), .SYS_RST(rst), .INSTR_VALID(iv), .EXEC_ADDR(ea), .NULLIFY(nul),
        .USER_MODE(usr), .FETCH_FAULT(ff), .BRANCH_TARGET_VALID(btv), .BRANCH_TARGET(bt),
        .RESERVED_OP(rop), .PRIV_REG_WRITE(prw), .TRAP_VALID(tv), .TRAP_VECTOR(tvec),
        .SW_BREAKPOINT_EMU(swb), .DATA_ACCESS_VALID(dav), .DATA_ADDR(da),
        .DATA_ADDR_UNDEFINED(dau), .REINIT_REQ(rin), .USER_TIMER_TWO_IRQ(lines[4]),
        .EXT_PIN_IRQ(lines[3]), .SERIAL_IRQ(lines[2]), .PARALLEL_IRQ(lines[1]),
        .TIMER_ONE_IRQ(lines[0]), .RETURN_REQ(rq), .VECTOR_BASE(vb),
        .BREAKPOINT_ADDRESS_REG(breakpoint_address_reg), .BREAKPOINT_ENABLE_BIT(bpe), .EXCEPTION_ENABLE_SET(ees),
        .LEVEL_WRITE(lw), .LEVEL_WRITE_DATA(lwd),
        .EXCEPTION_ENABLE_BIT(eeb), .PROCESSOR_LEVEL(pl), .SAVED_LEVEL(slv),
        .SAVED_ENABLE(sen), .SAVED_NULLIFY_FLAG(snf), .TAKE(take), .TARGET_ADDR(tgt),
        .SAVED_ADDR(sav), .RESUME_NEXT(rnx), .SKIP_RETURN_INSTR(skp), .RETURN_DONE(rdn),
        .KILL_INSTR(kil), .MIS_DATA_PENDING(mdp), .DATA_FAULT_PENDING(dfp)
    );

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic fail(input string m);
        err_count++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask

    task automatic chk(input logic c, input string m);
        total_checks++;
        if (c !== 1'b1)
            fail(m);
    endtask

    task automatic report_and_stop;
        $display("checks %0d, errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic idle;
        {ff, btv, rop, prw, tv, dav, dau, rin, rq, ees, usr, nul, bpe, lw} = '0;
        {raise, drop} = '0;
    endtask

    task automatic step;
        @(posedge clk);
        #1;
    endtask

    task automatic expect_entry(input logic [11:0] o, input logic c);
        exp_q.push_back('{vb | {20'h0, o}, ea, c, 4'hf});
    endtask

    // Each source is held for exactly one instruction cycle, since synchronous
    // sources are not held by the unit and must be taken in their own cycle.
    task automatic fire(input int k);
        ea = $urandom() & 32'h0fff_fffc;
        case (k)
            0: ff = 1'b1;
            1: {btv, bt} = {1'b1, ea | 32'h2};
            2: {usr, prw} = 2'b11;
            3: {usr, tv, tvec} = {2'b11, 8'h40};
            4: rop = 1'b1;
            5: {tv, tvec} = {1'b1, 8'h45};
            default: rin = 1'b1;
        endcase
        expect_entry(ofs[k], k != 6);
        step();
        idle();
        // The re-initialise edge is latched first and taken one cycle later.
        if (k == 6)
            step();
    endtask

    task automatic set_enable;
        ees = 1'b1;
        step();
        ees = 1'b0;
    endtask

    // The watcher pops the oldest note at every entry; an entry with no note is a fault.
    // Outputs are looked at mid-cycle, once the launching edge has settled.
    always @(negedge clk)
    begin
        if (take === 1'b1)
        begin
            total_checks++;
            if (exp_q.size() == 0)
                fail("entry taken with none expected");
            else
            begin
                e = exp_q.pop_front();
                if (tgt !== e.tgt || pl !== e.lvl || kil !== 1'b1 || (e.chk && sav !== e.sav))
                    fail("entry target, level or saved address wrong");
            end
        end
    end

    initial
    begin
        #20000;
        err_count++;
        report_and_stop();
    end

    initial
    begin
        void'($urandom(32'hd1a779cc));
        rst = 1'b1;
        {iv, swb, ea, bt, da, tvec, breakpoint_address_reg, lwd} = '0;
        idle();
        vb = $urandom() & 32'hffff_f000;
        repeat (3) @(posedge clk);
        #1;
        iv = 1'b1;
        rst = 1'b0;
        chk(pl === 4'hf && tgt === 32'h0 && eeb === 1'b0, "state after reset");
        foreach (seq[i]) fire(seq[i]);
        repeat (2) step();
        chk(rnx === 1'b1, "software trap must resume at next instruction");
        {ff, nul} = 2'b11;
        step();
        idle();
        {ff, btv, bt, usr, prw} = {2'b11, ea | 32'h1, 2'b11};
        expect_entry(12'h010, 1'b1);
        step();
        idle();
        breakpoint_address_reg = ea;
        bpe = 1'b1;
        step();
        idle();
        set_enable();
        {bpe, nul} = 2'b11;
        exp_q.push_back('{vb | 32'h080, breakpoint_address_reg, 1'b1, 4'hf});
        step();
        idle();
        chk(snf === 1'b1 && sen === 1'b1, "nullify or enable not saved");
        {dav, da} = {1'b1, ($urandom() & 32'h0fff_fffc) | 32'h1};
        step();
        chk(mdp === 1'b1, "misaligned data not pending");
        {dav, dau, da} = {2'b11, $urandom() & 32'h0fff_fffc};
        step();
        idle();
        repeat (2) step();
        chk(dfp === 1'b1 && mdp === 1'b1, "data requests not held");
        expect_entry(12'h050, 1'b1);
        set_enable();
        repeat (2) step();
        chk(dfp === 1'b1, "data fault lost while waiting");
        expect_entry(12'h060, 1'b1);
        set_enable();
        repeat (2) step();
        raise = 5'h11;
        step();
        raise = 5'h00;
        {lw, lwd, ees} = {1'b1, 4'h0, 1'b1};
        exp_q.push_back('{vb | 32'h2b0, ea, 1'b1, 4'hb});
        step();
        idle();
        repeat (2) step();
        chk(pl === 4'hb && slv === 4'h0 && sen === 1'b1, "irq status wrong");
        {drop, rq} = {5'h10, 1'b1};
        step();
        idle();
        chk(rdn === 1'b1 && skp === 1'b0, "return not signalled");
        chk(pl === 4'h0 && eeb === 1'b1, "return did not restore status");
        exp_q.push_back('{vb | 32'h230, ea, 1'b1, 4'h3});
        drop = 5'h01;
        step();
        idle();
        step();
        rst = 1'b1;
        step();
        chk(pl === 4'hf && tgt === 32'h0 && mdp === 1'b0 && dfp === 1'b0, "mid-run reset");
        rst = 1'b0;
        repeat (3) step();
        chk(exp_q.size() == 0, "expected entries never taken");
        report_and_stop();
    end
endmodule // testbench
